// *** register_width_table.sv ***
// Address to width lookup for the serial register access port
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module register_width_table (
  input wire logic [4:0] addr,
  output logic [5:0] width_bits,
  output logic [2:0] byte_count,
  output logic [7:0] first_byte_mask,
  output logic assigned
);

  logic [5:0] pad_bits;

  // Width per address; unassigned ones still move one byte
  always_comb begin
    assigned = 1'b1;
    case (addr)
      `SP_ADDR_WAVEFORM: width_bits = `SP_WIDTH_WAVEFORM;
      `SP_ADDR_ENERGY: width_bits = `SP_WIDTH_ENERGY;
      `SP_ADDR_ENERGY_CLR: width_bits = `SP_WIDTH_ENERGY;
      `SP_ADDR_STATUS: width_bits = `SP_WIDTH_STATUS;
      `SP_ADDR_STATUS_CLR: width_bits = `SP_WIDTH_STATUS;
      `SP_ADDR_MODE: width_bits = `SP_WIDTH_MODE;
      `SP_ADDR_FREQ_DEN: width_bits = `SP_WIDTH_FREQ_DEN;
      `SP_ADDR_CH1_OFFSET: width_bits = `SP_WIDTH_CH1_OFFSET;
      `SP_ADDR_CH2_OFFSET: width_bits = `SP_WIDTH_CH2_OFFSET;
      `SP_ADDR_PGA_GAIN: width_bits = `SP_WIDTH_PGA_GAIN;
      default: begin
        width_bits = `SP_WIDTH_UNASSIGNED;
        assigned = 1'b0;
      end
    endcase
  end

  // Whole bytes, and the unused high bits of the first byte
  assign byte_count = 3'((width_bits + 6'h07) >> 3);
  assign pad_bits = {byte_count, 3'h0} - width_bits;
  assign first_byte_mask = 8'hFF >> pad_bits[2:0];

endmodule : register_width_table

// *** serial_port_consts.svh ***
// Constants for the serial register access port: command layout, widths, timing
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// Command byte layout
`define SP_CMD_BITS 8
`define SP_ADDR_BITS 5
`define SP_DIR_BIT 7
`define SP_DIR_WRITE 1'b1

// Longest read register in bytes, longest write register in bytes
`define SP_MAX_RD_BYTES 5
`define SP_MAX_WR_BYTES 3

// Host spacing between write bytes, and after a write before a read
`define SP_WRITE_GAP_NS 4000
`define SP_REF_PERIOD_NS 25
`define SP_WRITE_GAP_CYCLES ((`SP_WRITE_GAP_NS + `SP_REF_PERIOD_NS - 1) / `SP_REF_PERIOD_NS)

// Register addresses with a defined width
`define SP_ADDR_WAVEFORM 5'h01
`define SP_ADDR_ENERGY 5'h02
`define SP_ADDR_ENERGY_CLR 5'h03
`define SP_ADDR_STATUS 5'h04
`define SP_ADDR_STATUS_CLR 5'h05
`define SP_ADDR_MODE 5'h06
`define SP_ADDR_FREQ_DEN 5'h07
`define SP_ADDR_CH1_OFFSET 5'h08
`define SP_ADDR_CH2_OFFSET 5'h09
`define SP_ADDR_PGA_GAIN 5'h0A

// Register widths in bits
`define SP_WIDTH_WAVEFORM 6'd24
`define SP_WIDTH_ENERGY 6'd40
`define SP_WIDTH_STATUS 6'd8
`define SP_WIDTH_MODE 6'd16
`define SP_WIDTH_FREQ_DEN 6'd12
`define SP_WIDTH_CH1_OFFSET 6'd8
`define SP_WIDTH_CH2_OFFSET 6'd6
`define SP_WIDTH_PGA_GAIN 6'd8
`define SP_WIDTH_UNASSIGNED 6'd8

`endif

// *** serial_port_pkg.sv ***
// Types shared by the serial register access port
package serial_port_pkg;

  // Where the serial engine stands within a transfer
  typedef enum logic [1:0] {
    PHASE_COMMAND,
    PHASE_WRITE,
    PHASE_READ
  } serial_phase_t;

endpackage : serial_port_pkg

// *** serial_register_access_port.sv ***
// Serial slave port giving a host read and write access to the device registers
`timescale 1ns/1ps
`include "serial_port_consts.svh"

// What this block does
// [R01] Power-on, reset pin low or select falling puts the port in command mode.
// [R02] Command byte is eight bits: top bit direction, low five bits address.
// [R03] Host writes with a command whose top bit is one.
// [R04] Transfer ends after the register's last bit; port returns to command mode.
// [R05] Serial input is sampled on every falling serial clock edge.
// [R06] Serial output data changes only on rising serial clock edges.
// [R07] Select falling resets the serial engine, whatever was in progress.
// [R08] Host keeps select low from first command bit to last data bit.
// [R09] Select rising mid-transfer abandons it and floats the output.
// [R10] With select tied low the host must finish every transfer.
// [R11] Write data capture starts on the falling edge after the command byte.
// [R12] Host finishes a write byte no sooner than 4 us after the previous one.
// [R13] A write byte cut short by select rising is never committed.
// [R14] Registers up to three bytes; first data byte lands in the top byte.
// [R15] Write data is right-justified; unused top bits of the first byte dropped.
// [R16] Host reads with a command whose top bit is zero.
// [R17] Output drives from first data bit, floats at last falling edge or select rise.
// [R18] Whole register is snapshot at read start so updates cannot tear it.
// [R19] Host waits 4 us after a write before sending a read command.
// [R20] Unassigned addresses complete the byte count but change no register.
module serial_register_access_port (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic din,
  output logic dout,
  output logic dout_en_b,
  output logic [4:0] rd_addr,
  input wire logic [39:0] rd_word,
  output logic rd_taken,
  output logic [4:0] rd_taken_addr,
  output logic wr_strobe,
  output logic [4:0] wr_addr,
  output logic [1:0] wr_lane,
  output logic [7:0] wr_byte,
  output logic wr_settling
);

  localparam int unsigned GAP_CYCLES = `SP_WRITE_GAP_CYCLES;
  localparam logic [7:0] GAP_COUNT = 8'(GAP_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Reset bridge into the serial clock domain

  logic link_hold;
  logic link_clear;

  // Held high while the core is in reset; a flop so the clear is glitch free
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      link_hold <= 1'b1;
    end else begin
      link_hold <= 1'b0;
    end
  end

  // [R01] command mode entry
  // [R07] select restarts engine
  // The serial clock may be stopped, so the clear must act without it
  assign link_clear = cs_b | link_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine, falling edge side

  serial_port_pkg::serial_phase_t phase;
  logic [2:0] bit_cnt;
  logic [2:0] byte_idx;
  logic [6:0] shift_in;
  logic [4:0] addr;
  logic [7:0] next_byte;
  logic byte_done;
  logic last_byte;
  logic [5:0] width_bits;
  logic [2:0] byte_count;
  logic [7:0] first_byte_mask;
  logic assigned;

  register_width_table width_lookup (
    .addr(addr),
    .width_bits(width_bits),
    .byte_count(byte_count),
    .first_byte_mask(first_byte_mask),
    .assigned(assigned)
  );

  // Byte assembly; din belongs to this clock and needs no synchroniser
  assign next_byte = {shift_in, din};
  assign byte_done = (bit_cnt == 3'h7);
  assign last_byte = (byte_idx == 3'(byte_count - 3'h1));

  // [R05] sample on falling edge
  always_ff @(negedge sclk or posedge link_clear) begin
    if (link_clear) begin
      shift_in <= 7'h00;
      bit_cnt <= 3'h0;
    end else begin
      shift_in <= next_byte[6:0];
      bit_cnt <= 3'(bit_cnt + 3'h1);
    end
  end

  // Phase and byte position; cleared by select high so aborts leave nothing behind
  always_ff @(negedge sclk or posedge link_clear) begin
    if (link_clear) begin
      phase <= serial_port_pkg::PHASE_COMMAND;
      byte_idx <= 3'h0;
      addr <= 5'h00;
    end else if (byte_done) begin
      unique case (phase)
        serial_port_pkg::PHASE_COMMAND: begin
          // [R02] decode command byte
          // [R03] top bit one writes
          // [R16] top bit zero reads
          // [R11] data follows at once
          addr <= next_byte[`SP_ADDR_BITS-1:0];
          byte_idx <= 3'h0;
          phase <= (next_byte[`SP_DIR_BIT] == `SP_DIR_WRITE) ?
                   serial_port_pkg::PHASE_WRITE : serial_port_pkg::PHASE_READ;
        end
        serial_port_pkg::PHASE_WRITE,
        serial_port_pkg::PHASE_READ: begin
          // [R04] back to command mode
          // [R20] full count for any address
          if (last_byte) begin
            phase <= serial_port_pkg::PHASE_COMMAND;
          end else begin
            byte_idx <= 3'(byte_idx + 3'h1);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write byte hand-off, serial side

  logic write_commit;
  logic [7:0] commit_byte;
  logic [1:0] commit_lane;
  logic wr_toggle;
  logic [7:0] wr_hold_byte;
  logic [1:0] wr_hold_lane;
  logic [4:0] wr_hold_addr;
  logic [2:0] lane_full;
  logic lane_fits;

  // [R14] first byte is top lane
  // Lane counted at full width so a 40-bit register cannot wrap into lane 0
  assign lane_full = 3'(byte_count - 3'h1 - byte_idx);
  assign lane_fits = (lane_full < 3'(`SP_MAX_WR_BYTES));
  assign commit_lane = lane_full[1:0];

  // [R13] only whole bytes commit
  // [R20] unassigned writes dropped
  // [R14] lanes above third dropped
  assign write_commit = byte_done && (phase == serial_port_pkg::PHASE_WRITE) && assigned &&
                        lane_fits;
  // [R15] drop unused top bits
  assign commit_byte = (byte_idx == 3'h0) ? (next_byte & first_byte_mask) : next_byte;

  // Held stable for the core; only the device reset clears it, not select,
  // so that the toggle never makes a false edge
  always_ff @(negedge sclk or posedge link_hold) begin
    if (link_hold) begin
      wr_toggle <= 1'b0;
      wr_hold_byte <= 8'h00;
      wr_hold_lane <= 2'h0;
      wr_hold_addr <= 5'h00;
    end else if (write_commit) begin
      wr_toggle <= ~wr_toggle;
      wr_hold_byte <= commit_byte;
      wr_hold_lane <= commit_lane;
      wr_hold_addr <= addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read shifter, rising edge side

  logic reading;
  logic rd_active;
  logic read_start;
  logic [5:0] align_shift;
  logic [39:0] aligned_word;
  logic [39:0] out_shift;
  logic rd_toggle;
  logic [4:0] rd_hold_addr;

  assign reading = (phase == serial_port_pkg::PHASE_READ);
  assign read_start = reading && !rd_active;
  // Left-justify the register's whole bytes so the top bit of its first byte goes out first
  // Limitation: rd_word is taken at the first rising edge of a read, so the
  // register file must hold it steady from the end of the command byte
  assign align_shift = {3'(3'(`SP_MAX_RD_BYTES) - byte_count), 3'h0};
  assign aligned_word = rd_word << align_shift;
  assign rd_addr = addr;

  // [R06] drive on rising edge
  // [R18] snapshot whole register
  always_ff @(posedge sclk or posedge link_clear) begin
    if (link_clear) begin
      rd_active <= 1'b0;
      out_shift <= 40'h00_0000_0000;
    end else begin
      rd_active <= reading;
      if (read_start) begin
        out_shift <= aligned_word;
      end else begin
        out_shift <= {out_shift[38:0], 1'b0};
      end
    end
  end

  // Tells the core a register was read, for clear-on-read registers;
  // the address is held here because select high clears the live one
  always_ff @(posedge sclk or posedge link_hold) begin
    if (link_hold) begin
      rd_toggle <= 1'b0;
      rd_hold_addr <= 5'h00;
    end else if (read_start) begin
      rd_toggle <= ~rd_toggle;
      rd_hold_addr <= addr;
    end
  end

  // [R17] drive window of a read
  // [R09] select high floats output
  // Phase drops on the last falling edge, select clears both flops at once
  assign dout = out_shift[39];
  assign dout_en_b = ~(rd_active & reading);

  ////////////////////////////////////////////////////////////////////////////
  // Core side: toggle synchronisers and strobes

  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic wr_event;
  logic rd_event;
  logic [7:0] settle_cnt;

  // Edge detect looks only at the second and third stages
  assign wr_event = wr_sync[2] ^ wr_sync[1];
  assign rd_event = rd_sync[2] ^ rd_sync[1];

  // Two-stage synchronisers plus an edge stage
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_toggle};
      rd_sync <= {rd_sync[1:0], rd_toggle};
    end
  end

  // Write strobe with byte, lane and address; hold regs are stable by now
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wr_strobe <= 1'b0;
      wr_byte <= 8'h00;
      wr_lane <= 2'h0;
      wr_addr <= 5'h00;
    end else begin
      wr_strobe <= wr_event;
      if (wr_event) begin
        wr_byte <= wr_hold_byte;
        wr_lane <= wr_hold_lane;
        wr_addr <= wr_hold_addr;
      end
    end
  end

  // Read notice; the held address settled before the toggle was seen
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_taken <= 1'b0;
      rd_taken_addr <= 5'h00;
    end else begin
      rd_taken <= rd_event;
      if (rd_event) begin
        rd_taken_addr <= rd_hold_addr;
      end
    end
  end

  // [R12] byte spacing window
  // [R19] write to read gap
  // Flags the window in which a further byte or read would be too early
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      settle_cnt <= 8'h00;
    end else if (wr_event) begin
      settle_cnt <= GAP_COUNT;
    end else if (settle_cnt != 8'h00) begin
      settle_cnt <= 8'(settle_cnt - 8'h01);
    end
  end

  assign wr_settling = (settle_cnt != 8'h00);

endmodule : serial_register_access_port

// *** spa_assertions.sv ***
// Concurrent checks on the core side and the output float of the serial register access port
`timescale 1ns/1ps
module spa_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input logic dout_en_b,
  input logic rd_taken,
  input logic wr_strobe,
  input logic [4:0] wr_addr,
  input logic [1:0] wr_lane,
  input logic [7:0] wr_byte,
  input logic wr_settling
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // A commit is one strobe followed by a quiet settling window
  sequence s_commit;
    wr_strobe ##1 (!wr_strobe && wr_settling) [*8];
  endsequence

  AST_SETTLE: assert property (wr_strobe |-> s_commit)
    else $error("strobe not followed by settling window");
  AST_RD_PULSE: assert property (rd_taken |=> !rd_taken)
    else $error("read pulse longer than one cycle");
  AST_FLOAT: assert property (cs_b |-> dout_en_b)
    else $error("output driven while deselected");
  AST_LANE: assert property (wr_strobe |-> wr_lane <= 2'h2)
    else $error("lane beyond third byte");
  AST_ONE_LANE: assert property (wr_strobe && wr_addr >= 5'h08 |-> wr_lane == 2'h0)
    else $error("lane above zero for a one-byte register");
  AST_ADDR: assert property (wr_strobe |-> wr_addr >= 5'h01 && wr_addr <= 5'h0A)
    else $error("commit to an unassigned address");
  AST_MASK12: assert property (wr_strobe && wr_addr == 5'h07 && wr_lane == 2'h1
    |-> wr_byte[7:4] == 4'h0)
    else $error("upper nibble kept for twelve-bit register");
  AST_MASK6: assert property (wr_strobe && wr_addr == 5'h09 |-> wr_byte[7:6] == 2'h0)
    else $error("upper bits kept for six-bit register");
  AST_RESET: assert property ($rose(rst_b) |-> !wr_strobe && !rd_taken && !wr_settling)
    else $error("strobe active straight after reset");
endmodule : spa_checker

// *** spa_host.sv ***
// Behavioural host that clocks frames, whole or cut short, into the serial port
`timescale 1ns/1ps
module spa_host (
  output logic sclk,
  output logic cs_b,
  output logic din,
  input wire logic dout,
  input wire logic dout_en_b
);
  logic last;
  logic float_seen;

  // Clock stands still high between frames; select rises just after
  // time zero so the serial engine sees a clean clearing edge
  initial begin
    sclk = 1'b1;
    din = 1'b0;
    last = 1'b0;
    float_seen = 1'b0;
    #1 cs_b = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Send nbits MSB first; stop aborts at that bit; miso gathers the line
  task automatic frame(input logic [63:0] mosi, input int nbits, input int stop,
                       output logic [63:0] miso);
    miso = 64'h0;
    cs_b = 1'b0;
    #40;
    for (int i = nbits - 1; i >= 0; i--) begin
      if (nbits - 1 - i == stop) break;
      din = mosi[i];
      #8 sclk = 1'b0;
      #16 sclk = 1'b1;
      #8;
      // Released line shows the inverse, never a stale copy
      last = dout_en_b ? ~last : dout;
      miso = {miso[62:0], last};
      if (i % 8 == 0) #5000;
    end
    float_seen = dout_en_b;
    cs_b = 1'b1;
    #40;
  endtask : frame

  // Shift bits with select left low, as when select is tied low
  task automatic bits(input logic [7:0] mosi, input int nbits);
    cs_b = 1'b0;
    #40;
    for (int i = nbits - 1; i >= 0; i--) begin
      din = mosi[i];
      #8 sclk = 1'b0;
      #16 sclk = 1'b1;
      #8;
    end
  endtask : bits
endmodule : spa_host

// *** tb_top.sv ***
// Top-level bench for the serial register access port
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sclk, cs_b, din, dout, dout_en_b, rd_taken, wr_strobe, wr_settling;
  logic [4:0] rd_addr, rd_taken_addr, wr_addr;
  logic [1:0] wr_lane;
  logic [7:0] wr_byte;
  logic [39:0] rd_word;
  logic [63:0] got;
  logic [14:0] seen[$];
  int fails = 0;
  int total_checks = 0;

  always #12.5 ref_clk = ~ref_clk;
  // Register file stand-in: the address repeated
  assign rd_word = {8{rd_addr}};

  serial_register_access_port u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk),
    .cs_b(cs_b), .din(din), .dout(dout), .dout_en_b(dout_en_b), .rd_addr(rd_addr),
    .rd_word(rd_word), .rd_taken(rd_taken), .rd_taken_addr(rd_taken_addr),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_lane(wr_lane), .wr_byte(wr_byte),
    .wr_settling(wr_settling));
  spa_host u_host (.sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout), .dout_en_b(dout_en_b));

  // Log every committed byte
  always @(posedge ref_clk) if (wr_strobe === 1'b1) seen.push_back({wr_addr, wr_lane, wr_byte});

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] act, input logic [63:0] exp);
    total_checks++;
    if (act !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, act);
    end
  endtask : check

  // Compare the logged commits, then forget them
  task automatic commits(input int n, input logic [44:0] exp);
    check("commit count", seen.size(), n);
    for (int k = 0; k < n && k < seen.size(); k++) check("commit", seen[k], exp[44 - 15 * k -: 15]);
    seen.delete();
  endtask : commits

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Hang guard
  initial begin
    #2000000;
    fails++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    u_host.frame({40'h0, 8'h86, 16'hA55A}, 24, 99, got);
    commits(2, {5'h06, 2'h1, 8'hA5, 5'h06, 2'h0, 8'h5A, 15'h0});
    $display("test two-byte write done");
    u_host.frame({40'h0, 8'h87, 16'hFABC}, 24, 99, got);
    commits(2, {5'h07, 2'h1, 8'h0A, 5'h07, 2'h0, 8'hBC, 15'h0});
    u_host.frame({48'h0, 8'h89, 8'hFF}, 16, 99, got);
    commits(1, {5'h09, 2'h0, 8'h3F, 30'h0});
    $display("test justified writes done");
    u_host.frame({32'h0, 8'h9F, 8'h00, 8'h04, 8'h00}, 32, 99, got);
    commits(0, 45'h0);
    check("read after unassigned", got[8:1], 8'h84);
    $display("test back-to-back done");
    u_host.frame({48'h0, 8'h86, 8'hA5}, 16, 12, got);
    commits(0, 45'h0);
    u_host.frame({48'h0, 8'h06, 8'h00}, 16, 11, got);
    check("float after abort", dout_en_b, 1);
    u_host.frame({48'h0, 8'h04, 8'h00}, 16, 99, got);
    check("read after abort", got[8:1], 8'h84);
    $display("test aborts done");
    u_host.frame({16'h0, 8'h02, 40'h0}, 48, 99, got);
    check("long read", got[40:1], {8{5'h02}});
    check("float after read", u_host.float_seen, 1);
    check("read address", rd_taken_addr, 5'h02);
    $display("test long read done");
    u_host.bits(8'h0F, 4);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    u_host.frame({48'h0, 8'h04, 8'h00}, 16, 99, got);
    check("read after reset", got[8:1], 8'h84);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule : tb_top

bind serial_register_access_port spa_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .cs_b(cs_b), .dout_en_b(dout_en_b), .rd_taken(rd_taken), .wr_strobe(wr_strobe),
  .wr_addr(wr_addr), .wr_lane(wr_lane), .wr_byte(wr_byte), .wr_settling(wr_settling));
